// File: rtl/adc_seq_regs.svh
// Register offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFF_CTRL_A        12'h000
`define OFF_CTRL_B        12'h004
`define OFF_INSEL         12'h008
`define OFF_RESULT_LOW    12'h00c
`define OFF_RESULT_HIGH   12'h010
`define OFF_SLEEP         12'h014

// ----------------------------------------
// Control A fields
// ----------------------------------------
`define BIT_ENABLE        7
`define BIT_START         6
`define BIT_AUTO          5
`define BIT_DONE          4
`define BIT_IRQ_EN        3
`define POS_PRESCALE      0
`define W_PRESCALE        3

// ----------------------------------------
// Input select fields
// ----------------------------------------
`define BIT_REF           6
`define BIT_LEFT_ADJ      5
`define POS_CHANNEL       0
`define W_CHANNEL         2

// ----------------------------------------
// Trigger source codes and sleep bits
// ----------------------------------------
`define W_TRIG_SEL        3
`define TRIG_FREE_RUN     3'h0
`define TRIG_DONE_FLAG    3'h1
`define BIT_SLEEP_ADC     0
`define BIT_IRQ_FLAG_EN   1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define RST_CTRL_A        8'h00
`define RST_CTRL_B        8'h00
`define RST_INSEL         8'h00
`define CYC_NORMAL        5'd13
`define CYC_FIRST         5'd25
`define SH_NORMAL_HALF    6'd3
`define SH_FIRST_HALF     6'd29
`define SH_AUTO_HALF      6'd4

`endif

// File: rtl/adc_seq_pkg.sv
// Types of the conversion sequencer.
// Assumes the register header supplies all numbers.
package adc_seq_pkg;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_wait = 3'b010,
		st_conv = 3'b100
	} conv_state_t;

	typedef struct packed {
		logic [1:0] channel;
		logic       reference;
	} input_sel_t;

	typedef struct packed {
		logic       sample;
		input_sel_t sel;
	} analog_ctl_t;

endpackage

// File: rtl/adc_seq.sv
// Conversion sequencer of a 10-bit successive-approximation converter.
// Assumes an APB master on pclk, an analog core with a result input and
// trigger sources arriving from other clock domains or pins.
`include "adc_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Function
// - Start bit begins conversion, clears at end
// - Channel change applies after running conversion
// - Trigger edge resets prescaler, starts conversion
// - Held trigger or busy edges ignored
// - Trigger flag must clear before retrigger
// - Done-flag trigger chains conversions unconditionally
// - Software start works under auto trigger
// - Prescaler runs only while enabled
// - Start waits next converter clock edge
// - Normal 13 cycles, first 25
// - Sample 1.5 cycles after normal start
// - Auto sample two cycles after trigger
// - Completion stores result, sets flag, clears start
// - Free running restarts, start stays high
// - Selection buffer locked until last conversion cycle
// - Free-run change affects conversion after next
// - Sleep entry starts noise-reduced conversion
// - Completion raises request even when awake
// - Other sleep modes leave converter on
// - Clearing enable aborts conversion
// - Writing zero to start is ignored
// - Low-byte read blocks updates until high
module adc_seq
	import adc_seq_pkg::*;
#(
	parameter int unsigned N_TRIG = 8
) (
	// APB
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Triggers, codes 2 and up; codes 0 and 1 are internal
	input  wire logic [N_TRIG-1:0]     trig_in,
	input  wire logic [N_TRIG-1:0]     trig_flag_in,
	output logic      [N_TRIG-1:0]     trig_flag_clr,
	// CPU sleep status
	input  wire logic                  cpu_halted,
	input  wire logic                  sleep_quiet,
	// Analog core
	input  wire logic [9:0]            core_result,
	output analog_ctl_t                analog_ctl,
	output logic                       conv_done_irq
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]       ctrl_a_ff;
	logic [7:0]       ctrl_b_ff;
	logic [7:0]       insel_ff;
	logic [1:0]       sleep_ff;
	logic [9:0]       result_ff;
	logic             blocked_ff;
	input_sel_t       sel_buf_ff;
	logic [7:0]       presc_ff;
	logic             aclk_ff;
	conv_state_t      state_ff;
	logic [5:0]       half_ff;
	logic             first_ff;
	logic             auto_conv_ff;
	logic             start_ff;
	logic             done_ff;
	logic [N_TRIG-1:0] trig_s1_ff;
	logic [N_TRIG-1:0] trig_s2_ff;
	logic             halt_s1_ff;
	logic             halt_s2_ff;
	logic             halt_s3_ff;

	logic             wr;
	logic             rd;
	logic             enable;
	logic             auto_en;
	logic [2:0]       tsel;
	logic             aclk_rise;
	logic             aclk_fall;
	logic             trig_level;
	logic             trig_edge;
	logic             sw_start;
	logic             sleep_start;
	logic             conv_end;
	logic             nxt_start;
	logic [4:0]       total_cyc;
	logic [5:0]       sh_half;
	logic             chain;

	assign wr      = psel && penable && pwrite;
	assign rd      = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign enable  = ctrl_a_ff[`BIT_ENABLE];
	assign auto_en = ctrl_a_ff[`BIT_AUTO];
	assign tsel    = ctrl_b_ff[`W_TRIG_SEL-1:0];
	assign chain   = auto_en && (tsel == `TRIG_FREE_RUN || tsel == `TRIG_DONE_FLAG);

	// ----------------------------------------
	// Trigger synchronisers
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < N_TRIG; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					trig_s1_ff[gi] <= 1'b0;
					trig_s2_ff[gi] <= 1'b0;
				end else begin
					trig_s1_ff[gi] <= trig_in[gi];
					trig_s2_ff[gi] <= trig_s1_ff[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_s1_ff <= 1'b0;
			halt_s2_ff <= 1'b0;
			halt_s3_ff <= 1'b0;
		end else begin
			halt_s1_ff <= cpu_halted;
			halt_s2_ff <= halt_s1_ff;
			halt_s3_ff <= halt_s2_ff;
		end
	end

	// Trigger level: an external flag source is its flag, so the flag
	// must be cleared before a new edge can appear
	always_comb begin
		trig_level = 1'b0;
		if (tsel >= 3'h2 && (32'(tsel) - 2) < N_TRIG) begin
			trig_level = trig_s2_ff[tsel - 3'h2] | trig_flag_in[tsel - 3'h2];
		end
	end

	logic trig_lvl_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			trig_lvl_ff <= 1'b0;
		else
			trig_lvl_ff <= trig_level;
	end
	assign trig_edge = auto_en && enable && trig_level && !trig_lvl_ff
		&& state_ff == st_idle;

	assign sw_start = wr && paddr == `OFF_CTRL_A && pwdata[`BIT_START]
		&& pwdata[`BIT_ENABLE];

	assign sleep_start = halt_s2_ff && !halt_s3_ff && sleep_quiet
		&& sleep_ff[`BIT_SLEEP_ADC] && enable && !auto_en
		&& ctrl_a_ff[`BIT_IRQ_EN] && state_ff == st_idle;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// held while off, reset on trigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			presc_ff <= 8'h00;
		else if (!enable || trig_edge)
			presc_ff <= 8'h00;
		else
			presc_ff <= presc_ff + 8'h01;
	end

	// divide by 2 to the power select plus one
	logic [2:0] ps;
	logic       aclk_nxt;
	assign ps       = ctrl_a_ff[`POS_PRESCALE +: `W_PRESCALE];
	assign aclk_nxt = enable && !trig_edge && presc_ff[ps];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			aclk_ff <= 1'b0;
		else
			aclk_ff <= aclk_nxt;
	end
	assign aclk_rise = aclk_nxt && !aclk_ff;
	assign aclk_fall = !aclk_nxt && aclk_ff;

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	// length by kind
	assign total_cyc = first_ff ? `CYC_FIRST : `CYC_NORMAL;
	assign sh_half = auto_conv_ff ? `SH_AUTO_HALF
		: (first_ff ? `SH_FIRST_HALF : `SH_NORMAL_HALF);
	assign conv_end = state_ff == st_conv && (aclk_rise || aclk_fall)
		&& half_ff == {total_cyc, 1'b0} - 6'd1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff     <= st_idle;
			half_ff      <= 6'd0;
			auto_conv_ff <= 1'b0;
		end else if (!enable && !sw_start) begin
			// abort on disable; a start written with enable still counts
			state_ff     <= st_idle;
			half_ff      <= 6'd0;
			auto_conv_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				st_idle: begin
					if (trig_edge) begin
						state_ff     <= st_conv;
						half_ff      <= 6'd0;
						auto_conv_ff <= 1'b1;
					end else if (sw_start || sleep_start) begin
						state_ff     <= st_wait;
						auto_conv_ff <= 1'b0;
					end
				end
				st_wait: begin
					if (aclk_rise) begin
						state_ff <= st_conv;
						half_ff  <= 6'd0;
					end
				end
				st_conv: begin
					if (conv_end) begin
						if (chain) begin
							state_ff     <= st_conv;
							auto_conv_ff <= 1'b0;
						end else begin
							state_ff <= st_idle;
						end
						half_ff <= 6'd0;
					end else if (aclk_rise || aclk_fall) begin
						half_ff <= half_ff + 6'd1;
					end
				end
			endcase
		end
	end

	// First-conversion marker set while disabled, cleared after one conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			first_ff <= 1'b1;
		else if (!enable)
			first_ff <= 1'b1;
		else if (conv_end)
			first_ff <= 1'b0;
	end

	// start bit shows busy
	// Rises with the request, falls in the edge that sets the done flag
	always_comb begin
		nxt_start = start_ff;
		if (!enable && !sw_start)
			nxt_start = 1'b0;
		else if (state_ff == st_idle && (trig_edge || sw_start || sleep_start))
			nxt_start = 1'b1;
		else if (conv_end && !chain)
			nxt_start = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			start_ff <= 1'b0;
		else
			start_ff <= nxt_start;
	end

	// done flag, write one clears, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			done_ff <= 1'b0;
		else if (conv_end)
			done_ff <= 1'b1;
		else if (wr && paddr == `OFF_CTRL_A && pwdata[`BIT_DONE])
			done_ff <= 1'b0;
	end
	assign conv_done_irq = done_ff && ctrl_a_ff[`BIT_IRQ_EN];

	// result store, blocked between low and high reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff  <= 10'h000;
			blocked_ff <= 1'b0;
		end else begin
			if (conv_end && !blocked_ff)
				result_ff <= core_result;
			if (rd && paddr == `OFF_RESULT_HIGH)
				blocked_ff <= 1'b0;
			else if (rd && paddr == `OFF_RESULT_LOW)
				blocked_ff <= 1'b1;
		end
	end

	// buffer tracks outside conversion and in last cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sel_buf_ff <= '0;
		else if (state_ff != st_conv || half_ff >= {total_cyc, 1'b0} - 6'd2)
			if (!(state_ff == st_idle && trig_edge))
				sel_buf_ff <= '{channel: insel_ff[`POS_CHANNEL +: `W_CHANNEL],
					reference: insel_ff[`BIT_REF]};
	end

	// One pclk pulse at the converter clock edge that reaches the sample point
	assign analog_ctl = '{sample: state_ff == st_conv && (aclk_rise || aclk_fall)
		&& half_ff == sh_half - 6'd1, sel: sel_buf_ff};

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_ff <= `RST_CTRL_A;
			ctrl_b_ff <= `RST_CTRL_B;
			insel_ff  <= `RST_INSEL;
			sleep_ff  <= 2'b00;
		end else if (wr) begin
			unique case (paddr)
				`OFF_CTRL_A:  ctrl_a_ff <= pwdata[7:0];
				`OFF_CTRL_B:  ctrl_b_ff <= {5'h00, pwdata[2:0]};
				`OFF_INSEL:   insel_ff  <= {1'b0, pwdata[6:5], 3'h0, pwdata[1:0]};
				`OFF_SLEEP:   sleep_ff  <= pwdata[1:0];
				default:      ;
			endcase
		end
	end

	// software clears external flags, so no pulse from here
	assign trig_flag_clr = '0;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [15:0] adj;
	assign adj = insel_ff[`BIT_LEFT_ADJ] ? {result_ff, 6'h00} : {6'h00, result_ff};

	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (rd) begin
			unique case (paddr)
				`OFF_CTRL_A: prdata = {24'h00_0000, ctrl_a_ff[7], start_ff, ctrl_a_ff[5],
					done_ff, ctrl_a_ff[3:0]};
				`OFF_CTRL_B:      prdata = {24'h00_0000, ctrl_b_ff};
				`OFF_INSEL:       prdata = {24'h00_0000, insel_ff};
				`OFF_RESULT_LOW:  prdata = {24'h00_0000, adj[7:0]};
				`OFF_RESULT_HIGH: prdata = {24'h00_0000, adj[15:8]};
				`OFF_SLEEP:       prdata = {30'h0000_0000, sleep_ff};
				default:          pslverr = 1'b1;
			endcase
		end
	end

endmodule

`default_nettype wire

// File: tb/adc_seq_checker.sv
// Concurrent checks on the sequencer's top-level ports.
// Assumes the register header and APB on pclk.
`include "adc_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
	import adc_seq_pkg::*;
#(
	parameter int unsigned N_TRIG = 8
) (
	// APB
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	// Converter side
	input wire logic [N_TRIG-1:0] trig_flag_clr,
	input wire analog_ctl_t       analog_ctl,
	input wire logic              conv_done_irq
);
	// --------
	// Helpers
	// --------
	logic        en_ff;
	logic        ie_ff;
	logic [11:0] ss_ff;
	logic        wr_a;
	assign wr_a = psel && penable && pwrite && paddr == `OFF_CTRL_A;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff <= 1'b0;
			ie_ff <= 1'b0;
		end else if (wr_a) begin
			en_ff <= pwdata[`BIT_ENABLE];
			ie_ff <= pwdata[`BIT_IRQ_EN];
		end
	end
	// Cycles since the last sample point, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ss_ff <= 12'hfff;
		else if (analog_ctl.sample)
			ss_ff <= 12'h000;
		else if (ss_ff != 12'hfff)
			ss_ff <= ss_ff + 12'h001;
	end
	// --------
	// Checks
	// --------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	flag_clr_zero_a: assert property (trig_flag_clr == '0)
		else $error("trigger flag clear driven");
	sample_pulse_a: assert property (analog_ctl.sample |=> !analog_ctl.sample)
		else $error("sample pulse too long");
	sel_locked_a: assert property (analog_ctl.sample |=> $stable(analog_ctl.sel) [*2])
		else $error("selection moved after sample");
	off_no_sample_a: assert property (!en_ff [*2] |-> !analog_ctl.sample)
		else $error("sample while disabled");
	irq_masked_a: assert property (!ie_ff [*2] |-> !conv_done_irq)
		else $error("irq while masked");
	start_sample_a: assert property (wr_a && pwdata[7:5] == 3'h6 && pwdata[2:0] == 3'h0
		|-> ##[1:40] analog_ctl.sample)
		else $error("no sample after start");
	unmapped_err_a: assert property (psel && penable && paddr > `OFF_SLEEP
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access accepted");
	done_after_a: assert property ($rose(conv_done_irq) && $past(ie_ff)
		|-> ss_ff >= 12'h010 && ss_ff <= 12'hbb8)
		else $error("completion without sample");
endmodule
bind adc_seq adc_seq_checker #(.N_TRIG(N_TRIG)) i_chk (
	.pclk         (pclk),
	.presetn      (presetn),
	.psel         (psel),
	.penable      (penable),
	.pwrite       (pwrite),
	.paddr        (paddr),
	.pwdata       (pwdata),
	.prdata       (prdata),
	.pslverr      (pslverr),
	.trig_flag_clr(trig_flag_clr),
	.analog_ctl   (analog_ctl),
	.conv_done_irq(conv_done_irq)
);
`default_nettype wire

// File: tb/adc_seq_tb.sv
// Directed testbench of the conversion sequencer over APB.
// Assumes nothing of wait states; trigger code 2 and sleep inputs driven by tests.
`include "adc_seq_regs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
	$display("unexpected %s exp %h got %h", nm, ex, got); end end
module adc_seq_tb
	import adc_seq_pkg::*;
;
	// --------
	// Signals
	// --------
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h0;
	logic [7:0]       trig_in = 8'h00;
	logic [7:0]       trig_flag_in = 8'h00;
	logic             cpu_halted = 1'b0;
	logic             sleep_quiet = 1'b0;
	logic [9:0]       core_result = 10'h000;
	wire logic [31:0] prdata;
	wire logic        pready;
	wire logic        pslverr;
	wire logic [7:0]  trig_flag_clr;
	analog_ctl_t      analog_ctl;
	wire logic        conv_done_irq;
	logic [31:0]      rdat;
	logic             rerr;
	int               error_cnt = 0;
	int               check_count = 0;
	int               cyc = 0;
	int               t0;
	int               n;
	always #5 pclk = ~pclk;
	adc_seq #(.N_TRIG(8)) i_dut (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.trig_in      (trig_in),
		.trig_flag_in (trig_flag_in),
		.trig_flag_clr(trig_flag_clr),
		.cpu_halted   (cpu_halted),
		.sleep_quiet  (sleep_quiet),
		.core_result  (core_result),
		.analog_ctl   (analog_ctl),
		.conv_done_irq(conv_done_irq)
	);
	// --------
	// Tasks
	// --------
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Idle edge after each transfer keeps strobes from toggling twice in one step
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic go(input logic [31:0] v);
		t0 = cyc;
		bus(1'b1, `OFF_CTRL_A, v);
		bus(1'b0, `OFF_CTRL_A, 32'h0);
		`CHK("busy", 1'b1, rdat[`BIT_START])
	endtask
	task automatic idle();
		do bus(1'b0, `OFF_CTRL_A, 32'h0); while (rdat[`BIT_START] === 1'b1);
		n = cyc - t0;
	endtask
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			summarize();
		end
	end
	// --------
	// Tests
	// --------
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, 12'(4 * i), 32'h0);
			`CHK("reset value", 32'h0, rdat)
		end
		bus(1'b0, 12'h018, 32'h0);
		`CHK("unmapped err", 1'b1, rerr)
		$display("test reset done");
		core_result <= 10'h2a5;
		bus(1'b1, `OFF_INSEL, 32'h0000_0002);
		go(32'h0000_00c8);
		bus(1'b1, `OFF_INSEL, 32'h0000_0001);
		`CHK("old channel", 2'h2, analog_ctl.sel.channel)
		idle();
		`CHK("first length", 1'b1, n >= 50 && n <= 64)
		`CHK("done flag", 1'b1, rdat[`BIT_DONE])
		`CHK("irq", 1'b1, conv_done_irq)
		`CHK("new channel", 2'h1, analog_ctl.sel.channel)
		bus(1'b0, `OFF_RESULT_LOW, 32'h0);
		`CHK("low byte", 8'ha5, rdat[7:0])
		bus(1'b0, `OFF_RESULT_HIGH, 32'h0);
		`CHK("high byte", 8'h02, rdat[7:0])
		$display("test first done");
		bus(1'b0, `OFF_RESULT_LOW, 32'h0);
		core_result <= 10'h155;
		go(32'h0000_00d8);
		bus(1'b1, `OFF_CTRL_A, 32'h0000_0088);
		bus(1'b0, `OFF_CTRL_A, 32'h0);
		`CHK("zero start", 1'b1, rdat[`BIT_START])
		idle();
		`CHK("normal length", 1'b1, n >= 27 && n <= 40)
		`CHK("lost irq", 1'b1, conv_done_irq)
		bus(1'b0, `OFF_RESULT_HIGH, 32'h0);
		`CHK("blocked high", 8'h02, rdat[7:0])
		$display("test normal done");
		for (int c = 0; c < 2; c++) begin
			bus(1'b1, `OFF_INSEL, 32'h0000_0043);
			bus(1'b1, `OFF_CTRL_B, 32'(c));
			go(32'h0000_00f8);
			`CHK("new ref", 1'b1, analog_ctl.sel.reference)
			repeat (80) @(posedge pclk);
			bus(1'b0, `OFF_CTRL_A, 32'h0);
			`CHK("chain busy", 1'b1, rdat[`BIT_START])
			`CHK("chain done", 1'b1, rdat[`BIT_DONE])
			bus(1'b1, `OFF_CTRL_A, 32'h0);
			bus(1'b0, `OFF_CTRL_A, 32'h0);
			`CHK("abort", 1'b0, rdat[`BIT_START])
		end
		bus(1'b0, `OFF_RESULT_LOW, 32'h0);
		`CHK("run low", 8'h55, rdat[7:0])
		bus(1'b0, `OFF_RESULT_HIGH, 32'h0);
		`CHK("run high", 8'h01, rdat[7:0])
		$display("test chain done");
		core_result <= 10'h0c3;
		bus(1'b1, `OFF_CTRL_B, 32'h0000_0002);
		bus(1'b1, `OFF_CTRL_A, 32'h0000_00b8);
		trig_in <= 8'h01;
		repeat (4) @(posedge pclk);
		bus(1'b0, `OFF_CTRL_A, 32'h0);
		`CHK("trig busy", 1'b1, rdat[`BIT_START])
		idle();
		`CHK("trig done", 1'b1, rdat[`BIT_DONE])
		repeat (30) @(posedge pclk);
		bus(1'b0, `OFF_CTRL_A, 32'h0);
		`CHK("held trig", 1'b0, rdat[`BIT_START])
		bus(1'b0, `OFF_RESULT_LOW, 32'h0);
		`CHK("trig low", 8'hc3, rdat[7:0])
		bus(1'b0, `OFF_RESULT_HIGH, 32'h0);
		`CHK("trig high", 8'h00, rdat[7:0])
		$display("test trigger done");
		trig_in <= 8'h00;
		bus(1'b1, `OFF_CTRL_A, 32'h0000_0098);
		bus(1'b1, `OFF_SLEEP, 32'h0000_0001);
		sleep_quiet <= 1'b1;
		cpu_halted <= 1'b1;
		repeat (4) @(posedge pclk);
		bus(1'b0, `OFF_CTRL_A, 32'h0);
		`CHK("sleep busy", 1'b1, rdat[`BIT_START])
		idle();
		`CHK("wake irq", 1'b1, conv_done_irq)
		cpu_halted <= 1'b0;
		sleep_quiet <= 1'b0;
		$display("test sleep done");
		summarize();
	end
endmodule
`default_nettype wire
